// File: rtl/ifgc_defs.svh
// Constants of the IF frequency gate counter: clock, map, codes and counts
`ifndef IFGC_DEFS_SVH
`define IFGC_DEFS_SVH

`define IFGC_CLK_HZ 40000000
`define IFGC_TICK_HZ 1000
`define IFGC_REF_1K 26'h00003E8
`define IFGC_REF_100K 26'h00186A0
`define IFGC_REF_900K 26'h00DBBA0
`define IFGC_ACC_MOD 27'h2625A00
`define IFGC_ACC_HALF 26'h1312D00

`define IFGC_ADDR_CFG 3'h0
`define IFGC_ADDR_PINSEL 3'h1
`define IFGC_ADDR_CMD 3'h2
`define IFGC_ADDR_COUNT 3'h3
`define IFGC_ADDR_ISTAT 3'h4
`define IFGC_ADDR_IMASK 3'h5

`define IFGC_CMD_CLEAR_BIT 0
`define IFGC_CMD_START_BIT 1
`define IFGC_ST_OPEN_BIT 0
`define IFGC_ST_GATE_BIT 1
`define IFGC_EV_DONE_BIT 0
`define IFGC_EV_SAT_BIT 1

`define IFGC_SEL_EXT 2'h0
`define IFGC_SEL_AM 2'h1
`define IFGC_SEL_FM 2'h2
`define IFGC_GT_1MS 2'h0
`define IFGC_GT_4MS 2'h1
`define IFGC_GT_8MS 2'h2
`define IFGC_GT_OPEN 2'h3
`define IFGC_MS_1 4'h1
`define IFGC_MS_4 4'h4
`define IFGC_MS_8 4'h8
`define IFGC_GP_A 2'h1
`define IFGC_GP_B 2'h2
`define IFGC_REFSEL_100K 2'h1
`define IFGC_REFSEL_900K 2'h2
`define IFGC_COUNT_MAX 16'hFFFF

`endif

// File: rtl/ifgc_pkg.sv
// Types shared by the IF frequency gate counter
package ifgc_pkg;
    typedef struct packed {
        logic [1:0] gate_time_select;
        logic [1:0] count_input_select;
    } ifgc_cfg_t;
    typedef struct packed {
        logic [1:0] ref_select;
        logic [1:0] gate_pin_select;
    } ifgc_pinsel_t;
    typedef struct packed {
        logic gate_b_en;
        logic gate_a_en;
        logic am_if_en;
        logic fm_if_en;
    } ifgc_pin_cfg_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM = 4'b0010,
        ST_OPEN = 4'b0100,
        ST_FREE = 4'b1000
    } ifgc_state_t;
endpackage

// File: rtl/ifgc_top.sv
// IF frequency gate counter: IF pin counting and external gate counting
`timescale 1ns/10ps
`include "ifgc_defs.svh"

// Notes on behaviour
// - Count holds at all ones until cleared
// - IF gate times divided from system clock
// - IF counts input rises; high at open counts
// - External gate counts reference rises, +1 -0
// - References divided from system clock
// - Select 10 is FM pin, gate 10 8ms
// - Select 00 is external gate counting
// - Gate pin select 01 routes pin A
// - Watchdog reset returns pins to input
// - Clock stop, CE reset release pin functions
// - Halt keeps pin configuration unchanged
// - Start raises status; IF gate opens on tick, external gate on gate rise
// - FM input halved, AM input undivided
// - External gate open rise to rise
module ifgc_top #(
    parameter int TICK_CYCLES = `IFGC_CLK_HZ / `IFGC_TICK_HZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic fm_if_input_pin,
    input wire logic am_if_input_pin,
    input wire logic ext_gate_pin_a,
    input wire logic ext_gate_pin_b,
    input wire logic watchdog_stack_reset,
    input wire logic ce_reset,
    input wire logic clock_stop,
    input wire logic halt,
    output ifgc_pkg::ifgc_pin_cfg_t pin_cfg,
    output logic gate_dir_clear,
    output logic irq
);
    import ifgc_pkg::*;

    ifgc_cfg_t cfg_reg;
    ifgc_pinsel_t pinsel_reg;
    ifgc_state_t state_reg;
    ifgc_pin_cfg_t pin_cfg_reg;
    logic [15:0] count_reg;
    logic [15:0] rdata_reg;
    logic [1:0] istat_reg;
    logic [1:0] imask_reg;
    logic irq_reg;
    logic gate_dir_clear_reg;
    logic gate_open_status_flag;
    logic gate_state_flag;
    logic [15:0] tick_cnt_reg;
    logic tick_reg;
    logic [25:0] acc_reg;
    logic ref_reg;
    logic fm_prev_reg;
    logic fm_div_reg;
    logic in_prev_reg;
    logic gate_prev_reg;
    logic [3:0] ms_left_reg;

    logic wr_ok;
    logic cmd_wr;
    logic start_wr;
    logic clear_wr;
    logic ext_mode;
    logic if_mode;
    logic release_fn;
    logic counting;
    logic cnt_in;
    logic cnt_rise;
    logic gate_in;
    logic gate_rise;
    logic close_ev;
    logic sat_ev;
    logic [25:0] ref_inc;
    logic [26:0] acc_sum;
    logic [3:0] ms_load;

    // Register writes are CPU actions and cannot occur while the CPU is halted
    assign wr_ok = wr & ~halt;
    assign cmd_wr = wr_ok & (addr == `IFGC_ADDR_CMD);
    assign start_wr = cmd_wr & wdata[`IFGC_CMD_START_BIT];
    assign clear_wr = cmd_wr & wdata[`IFGC_CMD_CLEAR_BIT];
    assign ext_mode = (cfg_reg.count_input_select == `IFGC_SEL_EXT);
    assign if_mode = (cfg_reg.count_input_select == `IFGC_SEL_AM) |
                     (cfg_reg.count_input_select == `IFGC_SEL_FM);
    assign release_fn = ce_reset | clock_stop;
    assign counting = (state_reg == ST_OPEN) | (state_reg == ST_FREE);

    always_comb begin
        unique case (cfg_reg.count_input_select)
            `IFGC_SEL_EXT: cnt_in = ref_reg;
            `IFGC_SEL_FM: cnt_in = fm_div_reg;
            `IFGC_SEL_AM: cnt_in = am_if_input_pin;
            default: cnt_in = 1'b0;
        endcase
    end

    always_comb begin
        unique case (pinsel_reg.gate_pin_select)
            `IFGC_GP_A: gate_in = ext_gate_pin_a;
            `IFGC_GP_B: gate_in = ext_gate_pin_b;
            default: gate_in = 1'b0;
        endcase
    end

    always_comb begin
        unique case (pinsel_reg.ref_select)
            `IFGC_REFSEL_100K: ref_inc = `IFGC_REF_100K;
            `IFGC_REFSEL_900K: ref_inc = `IFGC_REF_900K;
            default: ref_inc = `IFGC_REF_1K;
        endcase
    end

    always_comb begin
        unique case (cfg_reg.gate_time_select)
            `IFGC_GT_4MS: ms_load = `IFGC_MS_4;
            `IFGC_GT_8MS: ms_load = `IFGC_MS_8;
            default: ms_load = `IFGC_MS_1;
        endcase
    end

    assign cnt_rise = counting & cnt_in & ~in_prev_reg;
    assign gate_rise = gate_in & ~gate_prev_reg;
    assign close_ev = (state_reg == ST_OPEN) &
                      (ext_mode ? gate_rise : (tick_reg & (ms_left_reg == `IFGC_MS_1)));
    assign sat_ev = cnt_rise & (count_reg == (`IFGC_COUNT_MAX - 16'h0001));
    assign acc_sum = {1'b0, acc_reg} + {1'b0, ref_inc};

    // 1 kHz tick divided down from the system clock
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // Phase accumulator keeps 900 kHz exact on average; edges jitter by one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= 26'h0000000;
            ref_reg <= 1'b0;
        end else begin
            if (acc_sum >= `IFGC_ACC_MOD) begin
                acc_reg <= 26'(acc_sum - `IFGC_ACC_MOD);
            end else begin
                acc_reg <= acc_sum[25:0];
            end
            ref_reg <= (acc_reg >= `IFGC_ACC_HALF);
        end
    end

    // FM input halved before it reaches the counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fm_prev_reg <= 1'b0;
            fm_div_reg <= 1'b0;
        end else begin
            fm_prev_reg <= fm_if_input_pin;
            if (fm_if_input_pin & ~fm_prev_reg) begin
                fm_div_reg <= ~fm_div_reg;
            end
        end
    end

    // Edge history; IF history is forced low outside the gate so a high level counts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_prev_reg <= 1'b0;
            gate_prev_reg <= 1'b0;
        end else begin
            in_prev_reg <= (counting | ext_mode) ? cnt_in : 1'b0;
            gate_prev_reg <= gate_in;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= '0;
            pinsel_reg <= '0;
        end else if (watchdog_stack_reset) begin
            cfg_reg <= '0;
            pinsel_reg <= '0;
        end else if (release_fn) begin
            cfg_reg.count_input_select <= `IFGC_SEL_EXT;
            pinsel_reg.gate_pin_select <= 2'h0;
        end else if (wr_ok) begin
            if (addr == `IFGC_ADDR_CFG) begin
                cfg_reg <= wdata[3:0];
            end
            if (addr == `IFGC_ADDR_PINSEL) begin
                pinsel_reg <= wdata[3:0];
            end
        end
    end

    // Pin functions follow the selections; nothing else changes them, so halt keeps them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_cfg_reg <= '0;
            gate_dir_clear_reg <= 1'b0;
        end else begin
            pin_cfg_reg.fm_if_en <= (cfg_reg.count_input_select == `IFGC_SEL_FM);
            pin_cfg_reg.am_if_en <= (cfg_reg.count_input_select == `IFGC_SEL_AM);
            pin_cfg_reg.gate_a_en <= ext_mode & (pinsel_reg.gate_pin_select == `IFGC_GP_A);
            pin_cfg_reg.gate_b_en <= ext_mode & (pinsel_reg.gate_pin_select == `IFGC_GP_B);
            // Only the watchdog path turns gate pins back to inputs
            gate_dir_clear_reg <= watchdog_stack_reset;
        end
    end

    // Gate sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            ms_left_reg <= 4'h0;
        end else if (watchdog_stack_reset | release_fn) begin
            state_reg <= ST_IDLE;
            ms_left_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (if_mode & (cfg_reg.gate_time_select == `IFGC_GT_OPEN)) begin
                        state_reg <= ST_FREE;
                    end else if (start_wr) begin
                        state_reg <= ST_ARM;
                    end
                end
                ST_ARM: begin
                    if (ext_mode ? gate_rise : tick_reg) begin
                        state_reg <= ST_OPEN;
                        ms_left_reg <= ms_load;
                    end
                end
                ST_OPEN: begin
                    if (close_ev) begin
                        state_reg <= ST_IDLE;
                    end else if (tick_reg & ~ext_mode) begin
                        ms_left_reg <= ms_left_reg - 4'h1;
                    end
                end
                ST_FREE: begin
                    // A start here is ignored; the open gate ends by reselection, watchdog reset, CE reset or clock stop
                    if (!(if_mode & (cfg_reg.gate_time_select == `IFGC_GT_OPEN))) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Gate status flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_open_status_flag <= 1'b0;
            gate_state_flag <= 1'b0;
        end else if (watchdog_stack_reset | release_fn) begin
            gate_open_status_flag <= 1'b0;
            gate_state_flag <= 1'b0;
        end else begin
            if (start_wr & (state_reg == ST_IDLE) &
                ~(if_mode & (cfg_reg.gate_time_select == `IFGC_GT_OPEN))) begin
                gate_open_status_flag <= 1'b1;
            end else if (close_ev) begin
                gate_open_status_flag <= 1'b0;
            end
            gate_state_flag <= ~ext_mode & (counting & ~close_ev | ((state_reg == ST_ARM) &
                               tick_reg) | (state_reg == ST_IDLE) & if_mode &
                               (cfg_reg.gate_time_select == `IFGC_GT_OPEN));
        end
    end

    // 16-bit counter
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
        end else if (clear_wr) begin
            count_reg <= 16'h0000;
        end else if (cnt_rise & (count_reg != `IFGC_COUNT_MAX)) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Interrupt status, mask and output; a new event beats a same-cycle clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            istat_reg <= 2'h0;
            imask_reg <= 2'h0;
            irq_reg <= 1'b0;
        end else begin
            if (wr_ok & (addr == `IFGC_ADDR_ISTAT)) begin
                istat_reg <= (istat_reg & ~wdata[1:0]) | {sat_ev, close_ev};
            end else begin
                istat_reg <= istat_reg | {sat_ev, close_ev};
            end
            if (wr_ok & (addr == `IFGC_ADDR_IMASK)) begin
                imask_reg <= wdata[1:0];
            end
            irq_reg <= |(istat_reg & imask_reg);
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
        end else if (rd) begin
            unique case (addr)
                `IFGC_ADDR_CFG: rdata_reg <= {12'h000, cfg_reg};
                `IFGC_ADDR_PINSEL: rdata_reg <= {12'h000, pinsel_reg};
                `IFGC_ADDR_CMD: rdata_reg <= {14'h0000, gate_state_flag,
                                              gate_open_status_flag};
                `IFGC_ADDR_COUNT: rdata_reg <= count_reg;
                `IFGC_ADDR_ISTAT: rdata_reg <= {14'h0000, istat_reg};
                `IFGC_ADDR_IMASK: rdata_reg <= {14'h0000, imask_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign rdata = rdata_reg;
    assign pin_cfg = pin_cfg_reg;
    assign gate_dir_clear = gate_dir_clear_reg;
    assign irq = irq_reg;
endmodule

// File: testbench/ifgc_properties.sv
// Port checker of the IF frequency gate counter
`timescale 1ns/10ps
`include "ifgc_defs.svh"
module ifgc_properties import ifgc_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic watchdog_stack_reset,
    input wire logic ce_reset,
    input wire logic clock_stop,
    input wire logic halt,
    input wire ifgc_pin_cfg_t pin_cfg,
    input wire logic gate_dir_clear,
    input wire logic irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire quiet = !(ce_reset || clock_stop || watchdog_stack_reset);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd && addr > 3'h5 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_dir_clear: assert property (watchdog_stack_reset |=> gate_dir_clear)
        else $error("gate direction clear missing");
    a_wdt_inputs: assert property (watchdog_stack_reset |-> ##2 pin_cfg == 4'h0)
        else $error("pins not released after watchdog reset");
    a_stop_if_off: assert property ((ce_reset || clock_stop) [*2] |=>
        !pin_cfg.fm_if_en && !pin_cfg.am_if_en) else $error("IF pins kept on stop");
    a_halt_keeps: assert property ((halt && quiet) [*3] |-> $stable(pin_cfg))
        else $error("pin setup changed in halt");
    a_fm_enable: assert property ((wr && !halt && quiet && addr == `IFGC_ADDR_CFG
        && wdata[1:0] == `IFGC_SEL_FM) ##1 (!wr && quiet) |=>
        pin_cfg.fm_if_en && !pin_cfg.am_if_en) else $error("FM select not routed");
    a_irq_masked: assert property ((wr && !halt && addr == `IFGC_ADDR_IMASK
        && wdata[1:0] == 2'h0) ##1 !wr |=> !irq) else $error("irq high while masked");
endmodule

bind ifgc_top ifgc_properties u_props (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .watchdog_stack_reset, .ce_reset, .clock_stop, .halt, .pin_cfg, .gate_dir_clear, .irq);

// File: testbench/ifgc_src.sv
// Signal sources for the IF input pins and the external gate pins
`timescale 1ns/10ps
module ifgc_src (
    input wire logic mclk,
    input wire logic rst_n,
    output logic if_sig,
    output logic gate_a,
    output logic gate_b
);
    logic [10:0] ph_reg;
    // Fastest legal IF rate: a rise every second cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            if_sig <= 1'b0;
        end else begin
            if_sig <= ~if_sig;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg <= 11'h000;
        end else begin
            ph_reg <= (ph_reg == 11'h7CF) ? 11'h000 : ph_reg + 11'h001;
        end
    end
    // Gate B runs at twice the rate of A so a wrong routing halves or doubles the count
    assign gate_a = ph_reg < 11'h3E8;
    assign gate_b = (ph_reg < 11'h1F4) || (ph_reg >= 11'h3E8 && ph_reg < 11'h5DC);
endmodule

// File: testbench/tb_ifgc_top.sv
// Self-checking bench of the IF frequency gate counter
`timescale 1ns/10ps
`include "ifgc_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("FAIL %0t got %h want %h", $time, a, b); end end
module tb_ifgc_top;
    import ifgc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wdr = 1'b0;
    logic ce = 1'b0;
    logic cstop = 1'b0;
    logic halt = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] v;
    logic if_sig, gate_a, gate_b, gate_dir_clear, irq;
    ifgc_pin_cfg_t pin_cfg;
    int err_count = 0;
    int tests_run = 0;
    // Short tick keeps the 8 ms gate at 160 cycles
    ifgc_top #(.TICK_CYCLES(20)) dut (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .fm_if_input_pin(if_sig), .am_if_input_pin(if_sig), .ext_gate_pin_a(gate_a),
        .ext_gate_pin_b(gate_b), .watchdog_stack_reset(wdr), .ce_reset(ce),
        .clock_stop(cstop), .halt, .pin_cfg, .gate_dir_clear, .irq);
    ifgc_src src (.mclk, .rst_n, .if_sig, .gate_a, .gate_b);
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic measure(input logic [15:0] cfg, input logic [15:0] lo,
        input logic [15:0] hi);
        int n;
        wr_reg(`IFGC_ADDR_CFG, cfg);
        repeat (20) @(posedge mclk);
        wr_reg(`IFGC_ADDR_CMD, 16'h0001);
        wr_reg(`IFGC_ADDR_CMD, 16'h0002);
        rd_reg(`IFGC_ADDR_CMD);
        `CHK(v[0], 1'b1)
        n = 0;
        while (v[0] !== 1'b0 && n < 3000) begin
            rd_reg(`IFGC_ADDR_CMD);
            n++;
        end
        `CHK(v[0], 1'b0)
        rd_reg(`IFGC_ADDR_COUNT);
        `CHK(v >= lo && v <= hi, 1'b1)
    endtask
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(3'h7);
        `CHK(v, 16'h0000)
        rd_reg(`IFGC_ADDR_CFG);
        `CHK(v, 16'h0000)
        `CHK(pin_cfg, 4'h0)
        measure(16'h0002, 16'h0005, 16'h0006);
        `CHK(pin_cfg.fm_if_en, 1'b1)
        measure(16'h000A, 16'h0028, 16'h0029);
        measure(16'h0005, 16'h0028, 16'h0029);
        wr_reg(`IFGC_ADDR_ISTAT, 16'h0003);
        wr_reg(`IFGC_ADDR_IMASK, 16'h0001);
        wr_reg(`IFGC_ADDR_PINSEL, 16'h0005);
        measure(16'h0000, 16'h0005, 16'h0006);
        `CHK(irq, 1'b1)
        rd_reg(`IFGC_ADDR_ISTAT);
        `CHK(v[0], 1'b1)
        wr_reg(`IFGC_ADDR_ISTAT, 16'h0001);
        repeat (2) @(posedge mclk);
        #1 `CHK(irq, 1'b0)
        wr_reg(`IFGC_ADDR_CMD, 16'h0001);
        rd_reg(`IFGC_ADDR_COUNT);
        `CHK(v, 16'h0000)
        rd_reg(`IFGC_ADDR_PINSEL);
        `CHK(v, 16'h0005)
        // Pin B with the 900 kHz reference: 22.5 reference periods per gate period
        wr_reg(`IFGC_ADDR_PINSEL, 16'h000A);
        measure(16'h0000, 16'h0016, 16'h0017);
        wr_reg(`IFGC_ADDR_CFG, 16'h0002);
        halt <= 1'b1;
        wr_reg(`IFGC_ADDR_CFG, 16'h0001);
        repeat (3) @(posedge mclk);
        #1 `CHK(pin_cfg.fm_if_en, 1'b1)
        halt <= 1'b0;
        rd_reg(`IFGC_ADDR_CFG);
        `CHK(v, 16'h0002)
        for (int i = 0; i < 2; i++) begin
            wr_reg(`IFGC_ADDR_CFG, 16'h0002);
            repeat (3) @(posedge mclk);
            ce <= (i == 0);
            cstop <= (i == 1);
            repeat (3) @(posedge mclk);
            ce <= 1'b0;
            cstop <= 1'b0;
            rd_reg(`IFGC_ADDR_CFG);
            `CHK(v[1:0], 2'h0)
            `CHK(pin_cfg.fm_if_en, 1'b0)
            `CHK(gate_dir_clear, 1'b0)
        end
        wr_reg(`IFGC_ADDR_PINSEL, 16'h0001);
        wdr <= 1'b1;
        @(posedge mclk);
        wdr <= 1'b0;
        #1 `CHK(gate_dir_clear, 1'b1)
        rd_reg(`IFGC_ADDR_PINSEL);
        `CHK(v, 16'h0000)
        `CHK(pin_cfg, 4'h0)
        // The done event of the pin B gate is still pending here
        `CHK(irq, 1'b1)
        wr_reg(`IFGC_ADDR_IMASK, 16'h0000);
        repeat (2) @(posedge mclk);
        #1 `CHK(irq, 1'b0)
        print_verdict();
    end
endmodule
